// ### acv_pkg.sv
// package with register map, reset values, selector codes and types of the three-point curve block
package acv_pkg;

    // register bus widths
    localparam int ACV_AW = 16;
    localparam int ACV_DW = 16;

    // register offsets of the current-capable input curve
    localparam logic [15:0] ACV_A_CURVE_SEL = 16'h0332;
    localparam logic [15:0] ACV_A_AI2_IN_LOW = 16'h0339;
    localparam logic [15:0] ACV_A_AI2_OUT_PCT_LOW = 16'h033a;
    localparam logic [15:0] ACV_A_AI2_IN_MID = 16'h033b;
    localparam logic [15:0] ACV_A_AI2_OUT_PCT_MID = 16'h033c;
    localparam logic [15:0] ACV_A_AI2_IN_HIGH = 16'h033d;
    localparam logic [15:0] ACV_A_AI2_OUT_PCT_HIGH = 16'h033e;
    // register offsets of the voltage input curve
    localparam logic [15:0] ACV_A_VIN_VOLT_LOW = 16'h033f;
    localparam logic [15:0] ACV_A_VIN_OUT_PCT_LOW = 16'h0340;
    localparam logic [15:0] ACV_A_VIN_VOLT_MID = 16'h0341;
    localparam logic [15:0] ACV_A_VIN_OUT_PCT_MID = 16'h0342;
    localparam logic [15:0] ACV_A_VIN_VOLT_HIGH = 16'h0343;
    localparam logic [15:0] ACV_A_VIN_OUT_PCT_HIGH = 16'h0344;
    // further control and status words
    localparam logic [15:0] ACV_A_INPUT_TYPE = 16'h0380;
    localparam logic [15:0] ACV_A_MAX_FREQ = 16'h0381;
    localparam logic [15:0] ACV_A_VIN_PCT = 16'h0382;
    localparam logic [15:0] ACV_A_AI2_PCT = 16'h0383;
    localparam logic [15:0] ACV_A_FREQ_CMD = 16'h0384;
    localparam logic [15:0] ACV_A_STATUS = 16'h0385;

    // reset values, hundredths of a volt, milliamp or percent
    localparam logic [15:0] ACV_RST_AI2_IN_LOW = 16'h0190;
    localparam logic [15:0] ACV_RST_AI2_PCT_LOW = 16'h0000;
    localparam logic [15:0] ACV_RST_AI2_IN_MID = 16'h04b0;
    localparam logic [15:0] ACV_RST_AI2_PCT_MID = 16'h1388;
    localparam logic [15:0] ACV_RST_AI2_IN_HIGH = 16'h07d0;
    localparam logic [15:0] ACV_RST_AI2_PCT_HIGH = 16'h2710;
    localparam logic [15:0] ACV_RST_VIN_VOLT_LOW = 16'h0000;
    localparam logic [15:0] ACV_RST_VIN_PCT_LOW = 16'h0000;
    localparam logic [15:0] ACV_RST_VIN_VOLT_MID = 16'h01f4;
    localparam logic [15:0] ACV_RST_VIN_PCT_MID = 16'h1388;
    localparam logic [15:0] ACV_RST_VIN_VOLT_HIGH = 16'h03e8;
    localparam logic [15:0] ACV_RST_VIN_PCT_HIGH = 16'h2710;
    localparam logic [15:0] ACV_RST_CURVE_SEL = 16'h0000;
    localparam logic [15:0] ACV_RST_INPUT_TYPE = 16'h0000;

    // full scales in hundredths
    localparam logic [15:0] ACV_PCT_FULL = 16'h2710;
    localparam logic [15:0] ACV_VOLT_FULL = 16'h03e8;
    localparam logic [15:0] ACV_MA_FULL = 16'h07d0;

    // selector codes
    localparam logic [15:0] ACV_CURVE_NORMAL = 16'h0000;
    localparam logic [15:0] ACV_CURVE_VIN = 16'h0001;
    localparam logic [15:0] ACV_CURVE_AI2 = 16'h0002;
    localparam logic [15:0] ACV_CURVE_BOTH = 16'h0003;
    localparam logic [15:0] ACV_TYPE_VOLT = 16'h0001;

    // status word bit positions
    localparam int ACV_ST_BUSY = 0;
    localparam int ACV_ST_FWD = 1;

    // one interpolation job for the divider
    typedef struct packed {
        logic neg;
        logic [15:0] base;
        logic [31:0] num;
        logic [15:0] den;
    } acv_seg_t;

    // sequencer states
    typedef enum logic [1:0] {ACV_IDLE, ACV_DO_VIN, ACV_DO_AI2, ACV_DO_FRQ} acv_state_t;

endpackage

// ### acv_div.sv
// iterative unsigned restoring divider shared by the curve sequencer
`timescale 1ns/100ps
`default_nettype none
module acv_div #(
    parameter int NW = 32,
    parameter int DW = 16
) (
    // clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // request
    input wire logic i_start,
    input wire logic [NW-1:0] i_num,
    input wire logic [DW-1:0] i_den,
    // answer
    output logic o_busy,
    output logic o_done,
    output logic [NW-1:0] o_quot
);
    localparam int CW = $clog2(NW + 1);

    logic [NW-1:0] quot_ff;
    logic [DW:0] rem_ff;
    logic [DW-1:0] den_ff;
    logic [CW-1:0] cnt_ff;
    logic busy_ff;
    logic done_ff;
    logic [DW:0] trial;

    // next partial remainder with the next numerator bit shifted in
    assign trial = {rem_ff[DW-1:0], quot_ff[NW-1]};

    // one quotient bit per enabled cycle, msb first
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            quot_ff <= '0;
            rem_ff <= '0;
            den_ff <= '0;
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (i_clk_en) begin
            done_ff <= 1'b0;
            if (i_start && !busy_ff) begin
                quot_ff <= i_num;
                rem_ff <= '0;
                den_ff <= i_den;
                cnt_ff <= CW'(NW);
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                if (trial >= {1'b0, den_ff}) begin
                    rem_ff <= trial - {1'b0, den_ff};
                    quot_ff <= {quot_ff[NW-2:0], 1'b1};
                end else begin
                    rem_ff <= trial;
                    quot_ff <= {quot_ff[NW-2:0], 1'b0};
                end
                cnt_ff <= cnt_ff - CW'(1);
                if (cnt_ff == CW'(1)) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
            end
        end
    end

    assign o_busy = busy_ff;
    assign o_done = done_ff;
    assign o_quot = quot_ff;
endmodule
`default_nettype wire

// ### acv_curve.sv
// three-point curve mapping of two analog readings to a frequency command
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module acv_curve
    import acv_pkg::*;
#(
    parameter logic [15:0] MAX_FREQ_RST = 16'h1770
) (
    // clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // register port
    input wire logic [ACV_AW-1:0] i_reg_addr,
    input wire logic [ACV_DW-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [ACV_DW-1:0] o_reg_rdata,
    // samples from the analog converter
    input wire logic [15:0] i_vin_sample,
    input wire logic i_vin_valid,
    input wire logic [15:0] i_ai2_sample,
    input wire logic i_ai2_valid,
    // command to the frequency reference path
    output logic [15:0] o_vin_pct,
    output logic [15:0] o_ai2_pct,
    output logic [15:0] o_freq_cmd,
    output logic o_fwd_dir,
    output logic o_curve_active,
    output logic o_cmd_valid
);
    // parameter words
    logic [15:0] ai2_in_low_ff, ai2_out_pct_low_ff, ai2_in_mid_ff, ai2_out_pct_mid_ff;
    logic [15:0] ai2_in_high_ff, ai2_out_pct_high_ff;
    logic [15:0] vin_volt_low_ff, vin_out_pct_low_ff, vin_volt_mid_ff, vin_out_pct_mid_ff;
    logic [15:0] vin_volt_high_ff, vin_out_pct_high_ff;
    logic [15:0] curve_sel_ff, input_type_ff, max_freq_ff;
    // sample capture and results
    logic [15:0] vin_x_ff, ai2_x_ff;
    logic pend_ff;
    acv_state_t state_ff;
    logic neg_ff;
    logic [15:0] base_ff;
    logic [15:0] vin_pct_ff, ai2_pct_ff, freq_ff;
    logic fwd_ff, valid_ff;
    logic [15:0] rdata_ff;
    // divider hookup
    logic div_start, div_busy, div_done;
    logic [31:0] div_quot;
    acv_seg_t job;
    logic [15:0] seg_result, ai2_x_lim, ai2_fs, ai2_now;
    logic signed [16:0] cmd_sum;
    logic signed [16:0] cmd_pct;
    logic [15:0] cmd_mag;
    logic vin_en, ai2_en;

    // clamp an unsigned word to a full scale
    function automatic logic [15:0] sat_u(input logic [15:0] v, input logic [15:0] lim);
        sat_u = (v > lim) ? lim : v;
    endfunction

    // clamp a signed word to plus or minus a full scale
    function automatic logic [15:0] sat_s(input logic [15:0] v, input logic [15:0] lim);
        logic signed [16:0] sv;
        sv = $signed({v[15], v});
        if (sv > $signed({1'b0, lim})) begin
            sat_s = lim;
        end else if (sv < -$signed({1'b0, lim})) begin
            sat_s = 16'(-$signed({1'b0, lim}));
        end else begin
            sat_s = v;
        end
    endfunction

    // pick the segment of one curve and set up its division
    function automatic acv_seg_t seg_calc(input logic [15:0] x, input logic [15:0] xl,
                                          input logic [15:0] xm, input logic [15:0] xh,
                                          input logic [15:0] yl, input logic [15:0] ym,
                                          input logic [15:0] yh);
        acv_seg_t s;
        logic signed [16:0] dy;
        logic [16:0] mag;
        logic [15:0] dx;
        s = '0;
        s.den = 16'h0001;
        dy = '0;
        dx = '0;
        if (x <= xl) begin
            s.base = 16'h0000;
        end else if (x >= xh) begin
            s.base = yh;
        end else if (x <= xm) begin
            s.base = yl;
            dy = $signed({ym[15], ym}) - $signed({yl[15], yl});
            dx = x - xl;
            s.den = xm - xl;
        end else begin
            s.base = ym;
            dy = $signed({yh[15], yh}) - $signed({ym[15], ym});
            dx = x - xm;
            s.den = xh - xm;
        end
        s.neg = dy[16];
        mag = dy[16] ? 17'(-dy) : 17'(dy);
        s.num = 32'(mag) * 32'(dx);
        return s;
    endfunction

    // selector decode
    assign vin_en = (curve_sel_ff == ACV_CURVE_VIN) || (curve_sel_ff == ACV_CURVE_BOTH);
    assign ai2_en = (curve_sel_ff == ACV_CURVE_AI2) || (curve_sel_ff == ACV_CURVE_BOTH);
    assign ai2_fs = (input_type_ff == ACV_TYPE_VOLT) ? ACV_VOLT_FULL : ACV_MA_FULL;
    assign ai2_x_lim = sat_u(ai2_x_ff, ai2_fs);

    // combined percent from the two curves, held to full scale; the current result is taken
    // straight from the divider so the frequency job never scales last sample's value
    assign ai2_now = ai2_en ? seg_result : 16'h0000;
    assign cmd_sum = $signed({vin_pct_ff[15], vin_pct_ff}) + $signed({ai2_now[15], ai2_now});
    always_comb begin
        if (cmd_sum > $signed({1'b0, ACV_PCT_FULL})) begin
            cmd_pct = $signed({1'b0, ACV_PCT_FULL});
        end else if (cmd_sum < -$signed({1'b0, ACV_PCT_FULL})) begin
            cmd_pct = -$signed({1'b0, ACV_PCT_FULL});
        end else begin
            cmd_pct = cmd_sum;
        end
    end
    assign cmd_mag = cmd_pct[16] ? 16'(-cmd_pct) : 16'(cmd_pct);

    // job handed to the divider in each state but ACV_DO_FRQ
    always_comb begin
        job = '0;
        job.den = 16'h0001;
        div_start = 1'b0;
        unique case (state_ff)
            ACV_IDLE: begin
                job = seg_calc(sat_u(vin_x_ff, ACV_VOLT_FULL), vin_volt_low_ff, vin_volt_mid_ff,
                               vin_volt_high_ff, vin_out_pct_low_ff, vin_out_pct_mid_ff,
                               vin_out_pct_high_ff);
                div_start = pend_ff;
            end
            ACV_DO_VIN: begin
                job = seg_calc(ai2_x_lim, ai2_in_low_ff, ai2_in_mid_ff, ai2_in_high_ff,
                               ai2_out_pct_low_ff, ai2_out_pct_mid_ff, ai2_out_pct_high_ff);
                div_start = div_done;
            end
            ACV_DO_AI2: begin
                job.neg = cmd_pct[16];
                job.num = 32'(cmd_mag) * 32'(max_freq_ff);
                job.den = ACV_PCT_FULL;
                div_start = div_done;
            end
            ACV_DO_FRQ: begin
                div_start = 1'b0;
            end
        endcase
    end

    // signed result of the finished interpolation
    assign seg_result = neg_ff ? 16'(base_ff - div_quot[15:0]) : 16'(base_ff + div_quot[15:0]);

    // shared divider
    acv_div #(
        .NW(32),
        .DW(16)
    ) u_div (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_start(div_start),
        .i_num(job.num),
        .i_den(job.den),
        .o_busy(div_busy),
        .o_done(div_done),
        .o_quot(div_quot)
    );

    // parameter writes, each curve point clamped to its documented range; selector, input type and max frequency stored as written
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ai2_in_low_ff <= ACV_RST_AI2_IN_LOW;
            ai2_out_pct_low_ff <= ACV_RST_AI2_PCT_LOW;
            ai2_in_mid_ff <= ACV_RST_AI2_IN_MID;
            ai2_out_pct_mid_ff <= ACV_RST_AI2_PCT_MID;
            ai2_in_high_ff <= ACV_RST_AI2_IN_HIGH;
            ai2_out_pct_high_ff <= ACV_RST_AI2_PCT_HIGH;
            vin_volt_low_ff <= ACV_RST_VIN_VOLT_LOW;
            vin_out_pct_low_ff <= ACV_RST_VIN_PCT_LOW;
            vin_volt_mid_ff <= ACV_RST_VIN_VOLT_MID;
            vin_out_pct_mid_ff <= ACV_RST_VIN_PCT_MID;
            vin_volt_high_ff <= ACV_RST_VIN_VOLT_HIGH;
            vin_out_pct_high_ff <= ACV_RST_VIN_PCT_HIGH;
            curve_sel_ff <= ACV_RST_CURVE_SEL;
            input_type_ff <= ACV_RST_INPUT_TYPE;
            max_freq_ff <= MAX_FREQ_RST;
        end else if (i_clk_en && i_reg_wr) begin
            unique case (i_reg_addr)
                ACV_A_AI2_IN_LOW: ai2_in_low_ff <= sat_u(i_reg_wdata, ACV_MA_FULL);
                ACV_A_AI2_OUT_PCT_LOW: ai2_out_pct_low_ff <= sat_u(i_reg_wdata, ACV_PCT_FULL);
                ACV_A_AI2_IN_MID: ai2_in_mid_ff <= sat_u(i_reg_wdata, ACV_MA_FULL);
                ACV_A_AI2_OUT_PCT_MID: ai2_out_pct_mid_ff <= sat_u(i_reg_wdata, ACV_PCT_FULL);
                ACV_A_AI2_IN_HIGH: ai2_in_high_ff <= sat_u(i_reg_wdata, ACV_MA_FULL);
                ACV_A_AI2_OUT_PCT_HIGH: ai2_out_pct_high_ff <= sat_u(i_reg_wdata, ACV_PCT_FULL);
                ACV_A_VIN_VOLT_LOW: vin_volt_low_ff <= sat_u(i_reg_wdata, ACV_VOLT_FULL);
                ACV_A_VIN_OUT_PCT_LOW: vin_out_pct_low_ff <= sat_s(i_reg_wdata, ACV_PCT_FULL);
                ACV_A_VIN_VOLT_MID: vin_volt_mid_ff <= sat_u(i_reg_wdata, ACV_VOLT_FULL);
                ACV_A_VIN_OUT_PCT_MID: vin_out_pct_mid_ff <= sat_s(i_reg_wdata, ACV_PCT_FULL);
                ACV_A_VIN_VOLT_HIGH: vin_volt_high_ff <= sat_u(i_reg_wdata, ACV_VOLT_FULL);
                ACV_A_VIN_OUT_PCT_HIGH: vin_out_pct_high_ff <= sat_s(i_reg_wdata, ACV_PCT_FULL);
                ACV_A_CURVE_SEL: curve_sel_ff <= i_reg_wdata;
                ACV_A_INPUT_TYPE: input_type_ff <= i_reg_wdata;
                ACV_A_MAX_FREQ: max_freq_ff <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // latest samples and a pending flag; a new sample wins over the start that clears it
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            vin_x_ff <= '0;
            ai2_x_ff <= '0;
            pend_ff <= 1'b0;
        end else if (i_clk_en) begin
            if (i_vin_valid) begin
                vin_x_ff <= i_vin_sample;
            end
            if (i_ai2_valid) begin
                ai2_x_ff <= i_ai2_sample;
            end
            if (i_vin_valid || i_ai2_valid) begin
                pend_ff <= 1'b1;
            end else if (div_start && state_ff == ACV_IDLE) begin
                pend_ff <= 1'b0;
            end
        end
    end

    // sequencer: voltage curve, current curve, then frequency scaling
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff <= ACV_IDLE;
            neg_ff <= 1'b0;
            base_ff <= '0;
            vin_pct_ff <= '0;
            ai2_pct_ff <= '0;
            freq_ff <= '0;
            fwd_ff <= 1'b1;
            valid_ff <= 1'b0;
        end else if (i_clk_en) begin
            valid_ff <= 1'b0;
            if (div_start) begin
                neg_ff <= job.neg;
                base_ff <= job.base;
            end
            unique case (state_ff)
                ACV_IDLE: begin
                    if (div_start) begin
                        state_ff <= ACV_DO_VIN;
                    end
                end
                ACV_DO_VIN: begin
                    if (div_done) begin
                        vin_pct_ff <= vin_en ? seg_result : 16'h0000;
                        state_ff <= ACV_DO_AI2;
                    end
                end
                ACV_DO_AI2: begin
                    if (div_done) begin
                        ai2_pct_ff <= ai2_now;
                        state_ff <= ACV_DO_FRQ;
                    end
                end
                ACV_DO_FRQ: begin
                    if (div_done) begin
                        freq_ff <= div_quot[15:0];
                        fwd_ff <= !neg_ff;
                        valid_ff <= 1'b1;
                        state_ff <= ACV_IDLE;
                    end
                end
            endcase
        end
    end

    // register reads, data in the cycle after the strobe
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_ff <= '0;
        end else if (i_clk_en) begin
            rdata_ff <= '0;
            if (i_reg_rd) begin
                unique case (i_reg_addr)
                    ACV_A_AI2_IN_LOW: rdata_ff <= ai2_in_low_ff;
                    ACV_A_AI2_OUT_PCT_LOW: rdata_ff <= ai2_out_pct_low_ff;
                    ACV_A_AI2_IN_MID: rdata_ff <= ai2_in_mid_ff;
                    ACV_A_AI2_OUT_PCT_MID: rdata_ff <= ai2_out_pct_mid_ff;
                    ACV_A_AI2_IN_HIGH: rdata_ff <= ai2_in_high_ff;
                    ACV_A_AI2_OUT_PCT_HIGH: rdata_ff <= ai2_out_pct_high_ff;
                    ACV_A_VIN_VOLT_LOW: rdata_ff <= vin_volt_low_ff;
                    ACV_A_VIN_OUT_PCT_LOW: rdata_ff <= vin_out_pct_low_ff;
                    ACV_A_VIN_VOLT_MID: rdata_ff <= vin_volt_mid_ff;
                    ACV_A_VIN_OUT_PCT_MID: rdata_ff <= vin_out_pct_mid_ff;
                    ACV_A_VIN_VOLT_HIGH: rdata_ff <= vin_volt_high_ff;
                    ACV_A_VIN_OUT_PCT_HIGH: rdata_ff <= vin_out_pct_high_ff;
                    ACV_A_CURVE_SEL: rdata_ff <= curve_sel_ff;
                    ACV_A_INPUT_TYPE: rdata_ff <= input_type_ff;
                    ACV_A_MAX_FREQ: rdata_ff <= max_freq_ff;
                    ACV_A_VIN_PCT: rdata_ff <= vin_pct_ff;
                    ACV_A_AI2_PCT: rdata_ff <= ai2_pct_ff;
                    ACV_A_FREQ_CMD: rdata_ff <= freq_ff;
                    ACV_A_STATUS: begin
                        rdata_ff[ACV_ST_BUSY] <= div_busy || (state_ff != ACV_IDLE);
                        rdata_ff[ACV_ST_FWD] <= fwd_ff;
                    end
                    default: rdata_ff <= '0; // unmapped reads as zero
                endcase
            end
        end
    end

    // outputs
    assign o_reg_rdata = rdata_ff;
    assign o_vin_pct = vin_pct_ff;
    assign o_ai2_pct = ai2_pct_ff;
    assign o_freq_cmd = freq_ff;
    assign o_fwd_dir = fwd_ff;
    assign o_curve_active = vin_en || ai2_en;
    assign o_cmd_valid = valid_ff;
endmodule
`default_nettype wire

// ### acv_curve_props.sv
// port assertions of the three-point curve block
`timescale 1ns/100ps
`default_nettype none
module acv_curve_props (
    // clock and control
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // register port and samples
    input wire logic [15:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire logic i_vin_valid,
    // command outputs
    input wire logic [15:0] o_vin_pct,
    input wire logic [15:0] o_ai2_pct,
    input wire logic [15:0] o_freq_cmd,
    input wire logic o_fwd_dir,
    input wire logic o_curve_active,
    input wire logic o_cmd_valid
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    a_rdata_idle_zero: assert property (i_clk_en && !i_reg_rd |=> o_reg_rdata == 16'h0000)
        else $error("read data not idle");
    a_cmd_one_cycle: assert property (i_clk_en && o_cmd_valid |=> !o_cmd_valid)
        else $error("command pulse too long");
    a_cmd_bounded: assert property (i_clk_en && i_vin_valid |-> ##[1:260] o_cmd_valid)
        else $error("no command after sample");
    a_off_zero: assert property (o_cmd_valid && !o_curve_active |-> o_vin_pct == 16'h0000
        && o_ai2_pct == 16'h0000 && o_freq_cmd == 16'h0000) else $error("disabled curve not zero");
    a_fwd_sign: assert property (o_cmd_valid |-> o_fwd_dir ==
        ($signed(o_vin_pct) + $signed({1'b0, o_ai2_pct}) >= 0)) else $error("direction wrong");
    a_ai2_range: assert property (o_ai2_pct <= 16'h2710) else $error("current pct range");
    a_vin_range: assert property ($signed(o_vin_pct) >= -16'sd10000
        && $signed(o_vin_pct) <= 16'sd10000) else $error("voltage pct range");
    a_cmd_stable: assert property (!o_cmd_valid |-> $stable(o_freq_cmd) && $stable(o_fwd_dir))
        else $error("command moved without pulse");
    a_freq_zero: assert property (o_cmd_valid && o_vin_pct == 16'h0000
        && o_ai2_pct == 16'h0000 |-> o_freq_cmd == 16'h0000) else $error("zero pct gives speed");
    a_sel_active: assert property (i_clk_en && i_reg_wr && i_reg_addr == 16'h0332
        && i_reg_wdata inside {16'h0001, 16'h0002, 16'h0003} |=> o_curve_active) else $error("curve not active");
endmodule
bind acv_curve acv_curve_props u_props (.i_core_clk, .i_sys_rst, .i_clk_en, .i_reg_addr, .i_reg_wdata,
    .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_vin_valid, .o_vin_pct, .o_ai2_pct, .o_freq_cmd,
    .o_fwd_dir, .o_curve_active, .o_cmd_valid);
`default_nettype wire

// ### acv_adc_model.sv
// analog converter model: one-cycle sample pulses, toggling word between them
`timescale 1ns/100ps
`default_nettype none
module acv_adc_model (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // conversion request
    input wire logic i_req,
    input wire logic [15:0] i_level,
    // converter outputs
    output logic [15:0] o_sample,
    output logic o_valid
);
    // word is only meaningful beside valid, so it flips every cycle without a request
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_valid <= 1'b0;
            o_sample <= 16'h0000;
        end else begin
            o_valid <= i_req;
            o_sample <= i_req ? i_level : ~o_sample;
        end
    end
endmodule
`default_nettype wire

// ### acv_curve_tb.sv
// self-checking bench of the three-point curve block
`timescale 1ns/100ps
`default_nettype none
module acv_curve_tb import acv_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, vreq = 1'b0, areq = 1'b0, en = 1'b1;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, vlev = 16'h0000, alev = 16'h0000;
    logic [15:0] rdata, vs, a2s, vp, ap, fq;
    logic vv, av, fd, ca, cv;
    int err_total = 0;
    int cmp_count = 0;
    // selector, voltage, current, expected voltage pct, current pct, frequency
    logic [15:0] rows [6][6] = '{
        '{16'h3, 16'h0fa, 16'h320, 16'h09c4, 16'h09c4, 16'h0bb8},
        '{16'h3, 16'h000, 16'h190, 16'h0000, 16'h0000, 16'h0000},
        '{16'h3, 16'h3e8, 16'h640, 16'h2710, 16'h1d4c, 16'h1770},
        '{16'h1, 16'h0fa, 16'h320, 16'h09c4, 16'h0000, 16'h05dc},
        '{16'h2, 16'h0fa, 16'h320, 16'h0000, 16'h09c4, 16'h05dc},
        '{16'h0, 16'h0fa, 16'h320, 16'h0000, 16'h0000, 16'h0000}};
    always #50 clk = ~clk;
    acv_curve u_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_vin_sample(vs),
        .i_vin_valid(vv), .i_ai2_sample(a2s), .i_ai2_valid(av), .o_vin_pct(vp), .o_ai2_pct(ap),
        .o_freq_cmd(fq), .o_fwd_dir(fd), .o_curve_active(ca), .o_cmd_valid(cv));
    acv_adc_model u_vadc (.i_core_clk(clk), .i_sys_rst(rst), .i_req(vreq), .i_level(vlev),
        .o_sample(vs), .o_valid(vv));
    acv_adc_model u_aadc (.i_core_clk(clk), .i_sys_rst(rst), .i_req(areq), .i_level(alev),
        .o_sample(a2s), .o_valid(av));
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // one sample on both inputs, then wait for the command pulse
    task automatic smp(input logic [15:0] v, input logic [15:0] a);
        int n;
        n = 0;
        @(posedge clk);
        vreq <= 1'b1;
        areq <= 1'b1;
        vlev <= v;
        alev <= a;
        @(posedge clk);
        vreq <= 1'b0;
        areq <= 1'b0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (cv !== 1'b1 && n < 400);
        if (n >= 400) err_total++;
    endtask
    // watchdog
    initial begin
        #3000000;
        err_total++;
        test_done;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdc(ACV_A_AI2_IN_MID, 16'h04b0);
        rdc(ACV_A_AI2_OUT_PCT_HIGH, 16'h2710);
        rdc(ACV_A_VIN_VOLT_MID, 16'h01f4);
        rdc(ACV_A_VIN_OUT_PCT_MID, 16'h1388);
        rdc(16'h0300, 16'h0000);
        foreach (rows[i]) begin
            wrr(ACV_A_CURVE_SEL, rows[i][0]);
            smp(rows[i][1], rows[i][2]);
            chk(vp, rows[i][3]);
            chk(ap, rows[i][4]);
            chk(fq, rows[i][5]);
            chk({15'h0000, fd}, 16'h0001);
        end
        // step at a 2 mA lowest point giving 10 percent
        wrr(ACV_A_CURVE_SEL, 16'h0002);
        wrr(ACV_A_AI2_IN_LOW, 16'h00c8);
        wrr(ACV_A_AI2_OUT_PCT_LOW, 16'h03e8);
        smp(16'h0000, 16'h00c8);
        chk(ap, 16'h0000);
        smp(16'h0000, 16'h00c9);
        chk(ap, 16'h03ec);
        smp(16'h0000, 16'h0064);
        chk(ap, 16'h0000);
        // negative voltage curve gives reverse rotation
        wrr(ACV_A_CURVE_SEL, 16'h0001);
        wrr(ACV_A_VIN_VOLT_LOW, 16'h0064);
        wrr(ACV_A_VIN_OUT_PCT_LOW, 16'hd8f0);
        smp(16'h012c, 16'h0000);
        chk(vp, 16'hf63c);
        chk(fq, 16'h05dc);
        chk({15'h0000, fd}, 16'h0000);
        smp(16'h0032, 16'h0000);
        chk(vp, 16'h0000);
        // clamping of writes and the volt reading of the current input
        wrr(ACV_A_AI2_OUT_PCT_MID, 16'hffff);
        rdc(ACV_A_AI2_OUT_PCT_MID, 16'h2710);
        wrr(ACV_A_VIN_VOLT_HIGH, 16'h0fff);
        rdc(ACV_A_VIN_VOLT_HIGH, 16'h03e8);
        wrr(ACV_A_CURVE_SEL, 16'h0002);
        wrr(ACV_A_INPUT_TYPE, 16'h0001);
        smp(16'h0000, 16'h05dc);
        chk(ap, 16'h2008);
        // writes are ignored while the clock enable is low
        en <= 1'b0;
        wrr(ACV_A_CURVE_SEL, 16'h0003);
        en <= 1'b1;
        rdc(ACV_A_CURVE_SEL, 16'h0002);
        // a second reset in mid-run restores the defaults
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(ACV_A_AI2_OUT_PCT_MID, 16'h1388);
        rdc(ACV_A_VIN_VOLT_LOW, 16'h0000);
        test_done;
    end
endmodule
`default_nettype wire
